// ===== shared/tmsc_pkg.sv
// Constants and carrier types for the task map switch control block.
// Assumes one mclk_in edge per processor bus cycle.
package tmsc_pkg;

	// Register port geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;

	// Register indices on the plain register port
	localparam logic [ADDR_W-1:0] REG_STATUS      = 4'h0;
	localparam logic [ADDR_W-1:0] REG_COUNTDOWN   = 4'h1;
	localparam logic [ADDR_W-1:0] REG_RUN_TASK    = 4'h2;
	localparam logic [ADDR_W-1:0] REG_TABLE_INDEX = 4'h3;
	localparam logic [ADDR_W-1:0] REG_TABLE_DATA  = 4'h4;

	// Field widths
	localparam int TASK_W  = 5;
	localparam int LPAGE_W = 5;
	localparam int PPAGE_W = 10;
	localparam int COUNT_W = 3;
	localparam int INDEX_W = TASK_W + LPAGE_W;

	// Status register field positions
	localparam int ST_SUPER_BIT  = 0;
	localparam int ST_ACTIVE_BIT = 1;
	localparam int ST_COUNT_LSB  = 2;
	localparam int ST_TASK_LSB   = 8;

	// Fixed task numbers
	localparam logic [TASK_W-1:0] TASK_OS  = 5'h00;
	localparam logic [TASK_W-1:0] TASK_DMA = 5'h01;

	// Reset values
	localparam logic                 RST_SUPER    = 1'b1;
	localparam logic [TASK_W-1:0]    RST_RUN_TASK = 5'h00;
	localparam logic [COUNT_W-1:0]   RST_COUNT    = 3'h0;
	localparam logic [PPAGE_W-1:0]   RST_PPAGE    = 10'h000;
	localparam logic [INDEX_W-1:0]   RST_INDEX    = 10'h000;
	localparam logic [DATA_W-1:0]    RST_RDATA    = 16'h0000;

	// Processor bus state, decoded from the two status lines
	typedef enum logic [3:0] {
		BUS_RUN    = 4'b0001,
		BUS_VECTOR = 4'b0010,
		BUS_SYNC   = 4'b0100,
		BUS_GRANT  = 4'b1000
	} tmsc_bus_e;

	// Processor status lines as they travel together
	typedef struct packed {
		logic bus_available;
		logic bus_status;
	} tmsc_status_s;

	// Register port request
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} tmsc_req_s;

endpackage : tmsc_pkg

// ===== hdl/tmsc_map.sv
// Mapping table: one physical page per task and logical page.
// Assumes writes and lookups come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none

module tmsc_map
	import tmsc_pkg::*;
(
	input  wire logic               mclk_in,
	input  wire logic               reset_n_in,
	input  wire logic               wr_in,
	input  wire logic [INDEX_W-1:0] wr_index_in,
	input  wire logic [PPAGE_W-1:0] wr_data_in,
	input  wire logic [INDEX_W-1:0] rd_index_in,
	output logic      [PPAGE_W-1:0] rd_data_out,
	input  wire logic [TASK_W-1:0]  task_in,
	input  wire logic [LPAGE_W-1:0] lpage_in,
	output logic      [PPAGE_W-1:0] ppage_out
);

	// Table storage, left unreset like any RAM
	logic [PPAGE_W-1:0] table_mem [0:(1<<INDEX_W)-1];

	////////////////////////////////////////////////////////////////////////
	// Software writes into the table
	always_ff @(posedge mclk_in) begin
		if (wr_in) begin
			table_mem[wr_index_in] <= wr_data_in;
		end
	end

	// Readback for software, one cycle late
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rd_data_out <= RST_PPAGE;
		end else begin
			rd_data_out <= table_mem[rd_index_in];
		end
	end

	// Task number and logical page join into the table index of the physical page
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ppage_out <= RST_PPAGE;
		end else begin
			ppage_out <= table_mem[{task_in, lpage_in}];
		end
	end

endmodule : tmsc_map

`default_nettype wire

// ===== hdl/tmsc_top.sv
// Task map switch control: picks the active task for every bus cycle.
// Assumes mclk_in ticks once per processor bus cycle and that the
// status and address pins come from outside this clock's domain.
//
// How it works
// - Vector fetch maps through the OS task
// - Vector fetch sets the sticky supervisor flag
// - Countdown write loads a 3-bit down counter
// - Underflow clears supervisor, run task maps next
// - No counting on DMA or dead cycles
// - DMA cycles leave pending countdown untouched
// - Task and logical page form 10-bit table index
// - Bus grant or halt maps through DMA task
// - Reset: supervisor set, run task cleared, idle
`timescale 1ns/1ns
`default_nettype none

module tmsc_top
	import tmsc_pkg::*;
(
	input  wire logic               mclk_in,
	input  wire logic               reset_n_in,
	input  wire logic               bus_available_in,
	input  wire logic               bus_status_in,
	input  wire logic [LPAGE_W-1:0] upper_addr_in,
	input  wire logic [ADDR_W-1:0]  reg_addr_in,
	input  wire logic [DATA_W-1:0]  reg_wdata_in,
	input  wire logic               reg_wr_in,
	input  wire logic               reg_rd_in,
	output logic      [DATA_W-1:0]  reg_rdata_out,
	output logic      [PPAGE_W-1:0] phys_page_out,
	output logic                    top_phys_line_out,
	output logic      [TASK_W-1:0]  active_task_out,
	output logic                    supervisor_out
);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	tmsc_status_s       status_meta_ff;
	tmsc_status_s       status_sync_ff;
	logic [LPAGE_W-1:0] addr_meta_ff;
	logic [LPAGE_W-1:0] addr_sync_ff;
	logic               ba_prev_ff;
	tmsc_bus_e          bus_state;
	tmsc_req_s          req;

	logic               supervisor_ff;
	logic               nxt_supervisor;
	logic               fuse_active_ff;
	logic               nxt_fuse_active;
	logic [COUNT_W-1:0] count_ff;
	logic [COUNT_W-1:0] nxt_count;
	logic [TASK_W-1:0]  run_task_ff;
	logic [TASK_W-1:0]  active_task_ff;
	logic [TASK_W-1:0]  nxt_active_task;
	logic [INDEX_W-1:0] table_index_ff;
	logic [DATA_W-1:0]  rdata_ff;
	logic               rd_table_ff;
	logic [PPAGE_W-1:0] table_rdata;
	logic               count_enable;
	logic               underflow;
	logic               load_count;

	// Write decode, shared by every writable register
	function automatic logic reg_hit(input tmsc_req_s r, input logic [ADDR_W-1:0] a);
		reg_hit = r.wr && (r.addr == a);
	endfunction : reg_hit

	assign req = '{wr: reg_wr_in, rd: reg_rd_in, addr: reg_addr_in, wdata: reg_wdata_in};

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; two cycles of latency is the cost of safe sampling

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			status_meta_ff <= '0;
			status_sync_ff <= '0;
			addr_meta_ff   <= '0;
			addr_sync_ff   <= '0;
		end else begin
			status_meta_ff <= '{bus_available: bus_available_in, bus_status: bus_status_in};
			status_sync_ff <= status_meta_ff;
			addr_meta_ff   <= upper_addr_in;
			addr_sync_ff   <= addr_meta_ff;
		end
	end

	// Bus available as seen one cycle earlier, for the dead cycle
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ba_prev_ff <= 1'b0;
		end else begin
			ba_prev_ff <= status_sync_ff.bus_available;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus state decode

	always_comb begin
		case ({status_sync_ff.bus_available, status_sync_ff.bus_status})
			2'b01:   bus_state = BUS_VECTOR;
			2'b10:   bus_state = BUS_SYNC;
			2'b11:   bus_state = BUS_GRANT;
			default: bus_state = BUS_RUN;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Countdown

	// Dead and DMA cycles freeze the count
	assign count_enable = !status_sync_ff.bus_available && !ba_prev_ff;
	assign load_count   = reg_hit(req, REG_COUNTDOWN);
	assign underflow    = fuse_active_ff && count_enable && (count_ff == RST_COUNT) && !load_count;

	always_comb begin
		nxt_count       = count_ff;
		nxt_fuse_active = fuse_active_ff;
		if (load_count) begin
			nxt_count       = req.wdata[COUNT_W-1:0];
			nxt_fuse_active = 1'b1;
		end else if (fuse_active_ff && count_enable) begin
			if (count_ff == RST_COUNT) begin
				nxt_fuse_active = 1'b0;
			end else begin
				nxt_count = count_ff - 3'h1;
			end
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			count_ff       <= RST_COUNT;
			fuse_active_ff <= 1'b0;
		end else begin
			count_ff       <= nxt_count;
			fuse_active_ff <= nxt_fuse_active;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Supervisor flag; a vector fetch beats an underflow in the same cycle

	always_comb begin
		nxt_supervisor = supervisor_ff;
		if (bus_state == BUS_VECTOR) begin
			nxt_supervisor = 1'b1;
		end else if (underflow) begin
			nxt_supervisor = 1'b0;
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			supervisor_ff <= RST_SUPER;
		end else begin
			supervisor_ff <= nxt_supervisor;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Run task key; software must set it before the countdown

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			run_task_ff <= RST_RUN_TASK;
		end else if (reg_hit(req, REG_RUN_TASK)) begin
			run_task_ff <= req.wdata[TASK_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Active task choice, registered so it moves only on cycle edges

	always_comb begin
		case (bus_state)
			BUS_VECTOR: nxt_active_task = TASK_OS;
			BUS_GRANT:  nxt_active_task = TASK_DMA;
			default:    nxt_active_task = nxt_supervisor ? TASK_OS : run_task_ff;
		endcase
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			active_task_ff <= TASK_OS;
		end else begin
			active_task_ff <= nxt_active_task;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Table index register

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			table_index_ff <= RST_INDEX;
		end else if (reg_hit(req, REG_TABLE_INDEX)) begin
			table_index_ff <= req.wdata[INDEX_W-1:0];
		end
	end

	// Page lookup; the unregistered next task lines up with the synchronised address
	tmsc_map u_map (
		.mclk_in     (mclk_in),
		.reset_n_in  (reset_n_in),
		.wr_in       (reg_hit(req, REG_TABLE_DATA)),
		.wr_index_in (table_index_ff),
		.wr_data_in  (req.wdata[PPAGE_W-1:0]),
		.rd_index_in (table_index_ff),
		.rd_data_out (table_rdata),
		.task_in     (nxt_active_task),
		.lpage_in    (addr_sync_ff),
		.ppage_out   (phys_page_out)
	);

	////////////////////////////////////////////////////////////////////////
	// Register reads; unmapped addresses read as zero

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rdata_ff    <= RST_RDATA;
			rd_table_ff <= 1'b0;
		end else begin
			rdata_ff    <= RST_RDATA;
			rd_table_ff <= req.rd && (req.addr == REG_TABLE_DATA);
			if (req.rd) begin
				if (req.addr == REG_STATUS) begin
					rdata_ff[ST_SUPER_BIT]                     <= supervisor_ff;
					rdata_ff[ST_ACTIVE_BIT]                    <= fuse_active_ff;
					rdata_ff[ST_COUNT_LSB +: COUNT_W]          <= count_ff;
					rdata_ff[ST_TASK_LSB +: TASK_W]            <= active_task_ff;
				end else if (req.addr == REG_COUNTDOWN) begin
					rdata_ff[COUNT_W-1:0] <= count_ff;
				end else if (req.addr == REG_RUN_TASK) begin
					rdata_ff[TASK_W-1:0] <= run_task_ff;
				end else if (req.addr == REG_TABLE_INDEX) begin
					rdata_ff[INDEX_W-1:0] <= table_index_ff;
				end
			end
		end
	end

	// Table data arrives from the lookup module's own read flop
	assign reg_rdata_out     = rd_table_ff ? {{(DATA_W-PPAGE_W){1'b0}}, table_rdata} : rdata_ff;
	// Left to system logic: write-protect flag or extra address bit
	assign top_phys_line_out = phys_page_out[PPAGE_W-1];
	assign active_task_out   = active_task_ff;
	assign supervisor_out    = supervisor_ff;

endmodule : tmsc_top

`default_nettype wire

// ===== tb/tmsc_properties.sv
// Port checker for the task map switch control.
// Assumes one clock; status pins reach the outputs 3 edges late.
`timescale 1ns/1ns
`default_nettype none
module tmsc_properties
	import tmsc_pkg::*;
(
	input wire logic               mclk_in,
	input wire logic               reset_n_in,
	input wire logic               bus_available_in,
	input wire logic               bus_status_in,
	input wire logic [LPAGE_W-1:0] upper_addr_in,
	input wire logic [ADDR_W-1:0]  reg_addr_in,
	input wire logic [DATA_W-1:0]  reg_wdata_in,
	input wire logic               reg_wr_in,
	input wire logic               reg_rd_in,
	input wire logic [DATA_W-1:0]  reg_rdata_out,
	input wire logic [PPAGE_W-1:0] phys_page_out,
	input wire logic               top_phys_line_out,
	input wire logic [TASK_W-1:0]  active_task_out,
	input wire logic               supervisor_out
);
	logic [TASK_W-1:0] run_ff;
	logic [2:0]        quiet_ff;
	logic              rst_seen_ff;
	////////////////////////////////////////////////////////////
	// Mirror of the run task key
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			run_ff <= RST_RUN_TASK;
		else if (reg_wr_in && reg_addr_in == REG_RUN_TASK)
			run_ff <= reg_wdata_in[TASK_W-1:0];
	end
	// Idle status run length; short so it saturates cheaply
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			quiet_ff <= 3'h0;
		else if (bus_available_in || bus_status_in)
			quiet_ff <= 3'h0;
		else if (quiet_ff != 3'h7)
			quiet_ff <= quiet_ff + 3'h1;
	end
	// Reset seen one edge earlier; left unreset so the very first edge,
	// where the outputs may not have settled yet, goes unchecked
	always_ff @(posedge mclk_in) begin
		rst_seen_ff <= !reset_n_in;
	end
	////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!reset_n_in);
	property p_vector;
		$past(!bus_available_in && bus_status_in, 3)
			|-> active_task_out == TASK_OS && supervisor_out;
	endproperty
	a_vector: assert property (p_vector) else $error("vector fetch not in OS map");
	property p_sticky;
		supervisor_out && !$past(bus_available_in && bus_status_in, 3)
			|-> active_task_out == TASK_OS;
	endproperty
	a_sticky: assert property (p_sticky) else $error("supervisor without OS map");
	property p_dma;
		$past(bus_available_in && bus_status_in, 3) |-> active_task_out == TASK_DMA;
	endproperty
	a_dma: assert property (p_dma) else $error("grant not in DMA map");
	property p_switch;
		$fell(supervisor_out) |-> active_task_out == $past(run_ff);
	endproperty
	a_switch: assert property (p_switch) else $error("wrong task after switch");
	property p_fuse1;
		reg_wr_in && reg_addr_in == REG_COUNTDOWN && reg_wdata_in[2:0] == 3'h1
			&& quiet_ff >= 3'h3 && !bus_available_in && !bus_status_in
			|-> ##3 !supervisor_out;
	endproperty
	a_fuse1: assert property (p_fuse1) else $error("count of one late");
	property p_freeze;
		$past(bus_available_in, 3) || $past(bus_available_in, 4) |-> !$fell(supervisor_out);
	endproperty
	a_freeze: assert property (p_freeze) else $error("switch in frozen cycle");
	property p_page;
		top_phys_line_out == phys_page_out[PPAGE_W-1];
	endproperty
	a_page: assert property (p_page) else $error("top line differs");
	property p_rdata;
		!$past(reg_rd_in) |-> reg_rdata_out == RST_RDATA;
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data outside slot");
	property p_reset;
		disable iff (1'b0) rst_seen_ff && !reset_n_in
			|-> supervisor_out && active_task_out == TASK_OS;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");
	c_vector: cover property ($rose(supervisor_out));
	c_switch: cover property ($fell(supervisor_out));
	c_dma: cover property (active_task_out == TASK_DMA);
endmodule : tmsc_properties
`default_nettype wire

// ===== tb/tmsc_cpu_model.sv
// Processor bus status model: holds one bus state for a set count.
// Assumes the bench starts a state with a one-cycle go pulse.
`timescale 1ns/1ns
`default_nettype none
module tmsc_cpu_model
	import tmsc_pkg::*;
(
	input  wire logic               mclk_in,
	input  wire logic               reset_n_in,
	input  wire logic               go_in,
	input  wire tmsc_status_s       kind_in,
	input  wire logic [3:0]         len_in,
	output tmsc_status_s            stat_out
);
	logic [3:0] left_ff;
	// Drive the state for len cycles, then back to running
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			stat_out <= '0;
			left_ff  <= 4'h0;
		end else if (go_in) begin
			stat_out <= kind_in;
			left_ff  <= len_in;
		end else if (left_ff > 4'h1) begin
			left_ff <= left_ff - 4'h1;
		end else begin
			left_ff  <= 4'h0;
			stat_out <= '0;
		end
	end
endmodule : tmsc_cpu_model
`default_nettype wire

// ===== tb/test_task_map_switch_control.sv
// Bench for the task map switch control with a bus status model.
// Assumes a 100 MHz clock and the register port of the package.
`timescale 1ns/1ns
`default_nettype none
module test_task_map_switch_control
	import tmsc_pkg::*;
;
	logic               mclk_in, reset_n_in, reg_wr_in, reg_rd_in, go;
	logic [ADDR_W-1:0]  reg_addr_in;
	logic [DATA_W-1:0]  reg_wdata_in, reg_rdata_out;
	logic [LPAGE_W-1:0] upper_addr_in;
	logic [PPAGE_W-1:0] phys_page_out, pp;
	logic               top_phys_line_out, supervisor_out;
	logic [TASK_W-1:0]  active_task_out, rt;
	logic [3:0]         len;
	logic [31:0]        rnd;
	tmsc_status_s       kind, stat;
	int                 err_count, num_checks, k;
	tmsc_top i_dut (.mclk_in, .reset_n_in, .bus_available_in(stat.bus_available),
		.bus_status_in(stat.bus_status), .upper_addr_in, .reg_addr_in, .reg_wdata_in,
		.reg_wr_in, .reg_rd_in, .reg_rdata_out, .phys_page_out, .top_phys_line_out,
		.active_task_out, .supervisor_out);
	tmsc_cpu_model i_cpu (.mclk_in, .reset_n_in, .go_in(go), .kind_in(kind),
		.len_in(len), .stat_out(stat));
	////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// Expected status word from its fields
	function automatic logic [DATA_W-1:0] exp_st(input logic s, input logic [TASK_W-1:0] t);
		exp_st = '0;
		exp_st[ST_SUPER_BIT] = s;
		exp_st[ST_TASK_LSB +: TASK_W] = t;
	endfunction : exp_st
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One register access; go starts a bus state on the same edge
	task automatic reg_op(input logic w, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input logic g);
		reg_wr_in <= w;
		reg_rd_in <= !w;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		go <= g;
		@(posedge mclk_in);
		reg_wr_in <= 1'b0;
		reg_rd_in <= 1'b0;
		go <= 1'b0;
		@(posedge mclk_in);
	endtask : reg_op
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		reg_op(1'b0, a, 16'h0000, 1'b0);
		chk(reg_rdata_out, e);
	endtask : rd_chk
	// Edges from the write edge until the supervisor flag drops
	task automatic wait_fall;
		k = 1;
		@(negedge mclk_in);
		while (supervisor_out && k < 30) begin
			@(negedge mclk_in);
			k++;
		end
		@(posedge mclk_in);
	endtask : wait_fall
	task automatic vector_fetch;
		kind <= 2'h1;
		len <= 4'h2;
		go <= 1'b1;
		@(posedge mclk_in);
		go <= 1'b0;
		repeat (8) @(posedge mclk_in);
		chk(DATA_W'(supervisor_out), 16'h0001);
		chk(DATA_W'(active_task_out), DATA_W'(TASK_OS));
	endtask : vector_fetch
	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done
	////////////////////////////////////////////////////////////
	initial begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end
	initial begin
		repeat (5000) @(posedge mclk_in);
		err_count++;
		test_done();
	end
	initial begin
		{reset_n_in, reg_wr_in, reg_rd_in, go, reg_addr_in, reg_wdata_in} = '0;
		{upper_addr_in, kind, len, err_count, num_checks} = '0;
		rnd = 32'hBCA3;
		repeat (12) @(posedge mclk_in);
		reset_n_in <= 1'b1;
		@(posedge mclk_in);
		rd_chk(REG_STATUS, exp_st(1'b1, TASK_OS));
		rd_chk(REG_RUN_TASK, 16'h0000);
		rd_chk(4'hF, 16'h0000);
		reg_op(1'b1, REG_STATUS, 16'hFFFF, 1'b0);
		rd_chk(REG_STATUS, exp_st(1'b1, TASK_OS));
		$display("reset test done");
		// Table lookups through the OS task at random pages
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			pp = rnd[20:11];
			reg_op(1'b1, REG_TABLE_INDEX, DATA_W'({TASK_OS, rnd[4:0]}), 1'b0);
			reg_op(1'b1, REG_TABLE_DATA, DATA_W'(pp), 1'b0);
			rd_chk(REG_TABLE_INDEX, DATA_W'({TASK_OS, rnd[4:0]}));
			rd_chk(REG_TABLE_DATA, DATA_W'(pp));
			upper_addr_in <= rnd[4:0];
			repeat (4) @(posedge mclk_in);
			chk(DATA_W'(phys_page_out), DATA_W'(pp));
			chk(DATA_W'(top_phys_line_out), DATA_W'(pp[PPAGE_W-1]));
		end
		$display("page test done");
		// Every countdown value, random run task each time
		for (int n = 0; n < 8; n++) begin
			rnd = lfsr(rnd);
			rt = rnd[TASK_W-1:0];
			reg_op(1'b1, REG_RUN_TASK, DATA_W'(rt), 1'b0);
			reg_op(1'b1, REG_COUNTDOWN, DATA_W'(n), 1'b0);
			wait_fall();
			chk(DATA_W'(k), DATA_W'(n + 1));
			chk(DATA_W'(active_task_out), DATA_W'(rt));
			vector_fetch();
		end
		$display("countdown test done");
		// Grant and sync stall a pending count of five for 4+1 cycles
		for (int j = 0; j < 2; j++) begin
			kind <= j ? 2'h3 : 2'h2;
			len <= 4'h4;
			reg_op(1'b1, REG_COUNTDOWN, 16'h0005, 1'b1);
			wait_fall();
			chk(DATA_W'(k), 16'h000B);
			vector_fetch();
		end
		$display("stall test done");
		// Count of three frozen at one by a grant, then reset mid-count;
		// the grant ends two edges before reset asserts, so none of its status is left in the checker's 3-edge window after reset
		kind <= 2'h3;
		len <= 4'h7;
		reg_op(1'b1, REG_COUNTDOWN, 16'h0003, 1'b1);
		repeat (4) @(posedge mclk_in);
		rd_chk(REG_STATUS, exp_st(1'b1, TASK_DMA) | (16'h0001 << ST_ACTIVE_BIT)
			| (16'h0001 << ST_COUNT_LSB));
		rd_chk(REG_COUNTDOWN, 16'h0001);
		reset_n_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		reset_n_in <= 1'b1;
		repeat (8) @(posedge mclk_in);
		rd_chk(REG_STATUS, exp_st(1'b1, TASK_OS));
		$display("second reset test done");
		test_done();
	end
endmodule : test_task_map_switch_control
bind tmsc_top tmsc_properties i_props (.mclk_in, .reset_n_in, .bus_available_in,
	.bus_status_in, .upper_addr_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
	.reg_rd_in, .reg_rdata_out, .phys_page_out, .top_phys_line_out,
	.active_task_out, .supervisor_out);
`default_nettype wire
